// [hdl/icbs_bank_save.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - only table-reference vectored interrupts are considered for saving.
// - priority-indexed bank enable bit must be set to save.
// - priorities 15 and beyond all use bank enable bit 15.
// - bank count must not exceed the nest upper limit.
// - count above limit or at 63 skips save, raises error code 1c.
// - bank start is init pointer minus count times bank size.
// - bank size 0x60 in mode 0, 0x90 in mode 1.
// - mode 0 stores 24 words downward from start minus 4.
// - mode 1 stores 35 words downward; slot minus 0x90 unused.
// - after last store the count increments and the handler starts in the same cycle.
// - while saving, only store protection faults are taken; others held.
// - higher priority exceptions may be taken once saving ends.
// - normal guest acceptance sets the interrupt-disable flag.
// - saving interrupt with no-disable bit 0 keeps the flag clear.
// - priorities 15 and beyond use no-disable bit 15.
// - host-mode interrupts never use the bank.
// - up to 63 nesting levels held in the bank count.
module icbs_bank_save (
   input wire logic clock, // 100 MHz
   input wire logic resetn, // async, active low
   input wire logic clockEn, // freezes all state when low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic irqAccept, // interrupt accepted, one cycle
   input wire logic irqGuest, // handled in guest mode
   input wire logic irqTableRef, // table-reference vectoring
   input wire logic [5:0] irqPrio, // priority level
   input wire logic [31:0] ctxPc, // interrupted pc
   input wire logic [31:0] ctxStatus, // guest status word
   input wire logic [31:0] ctxCause, // guest interrupt cause
   input wire logic [31:0] ctxFpu, // fpu status
   output logic [4:0] gprIdx, // register file read index
   input wire logic [31:0] gprData, // register file read data
   output logic memReq, // word write request
   output logic [31:0] memAddr, // word write address
   output logic [31:0] memWdata, // word write data
   input wire logic memDone, // write finished
   input wire logic memProtViol, // protection fault with memDone
   output logic holdOff, // other interrupts and exceptions held
   output logic handlerStart, // start handler, pulse
   output logic bankUsed, // context saved, with handlerStart
   output logic guestIrqDisable, // flag value, with handlerStart
   output logic system_error_exc, // depth error, pulse
   output logic [15:0] sysErrCode, // low cause bits
   output logic memProtExc // store protection fault, pulse
);
   typedef enum logic {IDLE, STORE} icbs_state_type;

   // bank size from mode
   function automatic logic [31:0] bankSize(input logic md);
      bankSize = md ? icbs_pkg::BANK_SIZE_MODE1 : icbs_pkg::BANK_SIZE_MODE0;
   endfunction : bankSize

   // start address of bank n
   function automatic logic [31:0] bankStart(input logic [31:0] ip, input logic [5:0] n,
                                             input logic md);
      bankStart = ip - 32'({26'h0, n} * bankSize(md));
   endfunction : bankStart

   // enable bits indexed by priority, low priorities share bit 15
   function automatic logic [3:0] prioIndex(input logic [5:0] p);
      prioIndex = (p >= 6'(icbs_pkg::LOW_PRIO_BIT)) ? icbs_pkg::LOW_PRIO_BIT : p[3:0];
   endfunction : prioIndex

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] enable_q, enable_d;
   logic modeSel_q, modeSel_d;
   logic [15:0] noDisable_q, noDisable_d;
   logic [5:0] bankCount_q, bankCount_d;
   logic [5:0] limit_q, limit_d;
   logic [31:0] initPtr_q, initPtr_d;
   icbs_state_type state_q, state_d;
   logic [5:0] wordIdx_q, wordIdx_d;
   logic [3:0] prioIdx_q, prioIdx_d;
   logic [31:0] start_q, start_d;
   logic memReq_q, memReq_d;
   logic [31:0] memAddr_q, memAddr_d;
   logic [31:0] memWdata_q, memWdata_d;
   logic handlerStart_q, handlerStart_d;
   logic bankUsed_q, bankUsed_d;
   logic irqDis_q, irqDis_d;
   logic system_error_exc_q, system_error_exc_d;
   logic memProtExc_q, memProtExc_d;
   logic apbWrite, apbRead, mapped;
   logic [5:0] selIdx;
   logic lastWord;
   icbs_pkg::icbs_src_type selSrc;
   logic [31:0] selData;
   logic [3:0] acceptIdx;
   logic candidate, depthOk;

   // slot after the current one, or slot 0 when idle
   assign selIdx = (state_q == IDLE) ? 6'h00 : wordIdx_q + 6'h01;
   assign lastWord = modeSel_q ? (wordIdx_q == icbs_pkg::WORDS_MODE1 - 6'h01)
                               : (wordIdx_q == icbs_pkg::WORDS_MODE0 - 6'h01);

   icbs_word_sel u_sel (
      .wordIdx(selIdx),
      .modeSel(modeSel_q),
      .src(selSrc),
      .gprIdx(gprIdx),
      .lastWord()
   );

   // data for the next slot; the cpu is stalled so sources are stable
   always_comb begin
      case (selSrc)
         icbs_pkg::SRC_PC: selData = ctxPc;
         icbs_pkg::SRC_STATUS: selData = ctxStatus;
         icbs_pkg::SRC_CAUSE: selData = ctxCause;
         icbs_pkg::SRC_FPU: selData = ctxFpu;
         default: selData = gprData;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states
   assign pready = 1'b1;
   assign apbWrite = psel && penable && pwrite;
   assign apbRead = psel && !pwrite;
   assign mapped = (paddr == icbs_pkg::OFS_CFG0) || (paddr == icbs_pkg::OFS_CFG1) ||
                   (paddr == icbs_pkg::OFS_COUNT) || (paddr == icbs_pkg::OFS_LIMIT) ||
                   (paddr == icbs_pkg::OFS_INITPTR) || (paddr == icbs_pkg::OFS_STATUS);
   assign pslverr = psel && penable && !mapped;

   // read mux, registered data only
   always_comb begin
      prdata = 32'h0000_0000;
      if (!apbRead) begin
         prdata = 32'h0000_0000;
      end else if (paddr == icbs_pkg::OFS_CFG0) begin
         prdata = {15'h0000, modeSel_q, enable_q};
      end else if (paddr == icbs_pkg::OFS_CFG1) begin
         prdata = {16'h0000, noDisable_q};
      end else if (paddr == icbs_pkg::OFS_COUNT) begin
         prdata = {26'h0, bankCount_q};
      end else if (paddr == icbs_pkg::OFS_LIMIT) begin
         prdata = {26'h0, limit_q};
      end else if (paddr == icbs_pkg::OFS_INITPTR) begin
         prdata = initPtr_q;
      end else if (paddr == icbs_pkg::OFS_STATUS) begin
         prdata = {31'h0, state_q == STORE};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // acceptance checks
   assign acceptIdx = prioIndex(irqPrio);
   assign candidate = irqGuest && irqTableRef && enable_q[acceptIdx];
   assign depthOk = (bankCount_q <= limit_q) && (bankCount_q != icbs_pkg::COUNT_MAX);

   // next state of sequencer and registers
   always_comb begin
      enable_d = enable_q;
      modeSel_d = modeSel_q;
      noDisable_d = noDisable_q;
      bankCount_d = bankCount_q;
      limit_d = limit_q;
      initPtr_d = initPtr_q;
      state_d = state_q;
      wordIdx_d = wordIdx_q;
      prioIdx_d = prioIdx_q;
      start_d = start_q;
      memReq_d = memReq_q;
      memAddr_d = memAddr_q;
      memWdata_d = memWdata_q;
      handlerStart_d = 1'b0;
      bankUsed_d = 1'b0;
      irqDis_d = irqDis_q;
      system_error_exc_d = 1'b0;
      memProtExc_d = 1'b0;
      // software writes; mode and pointer locked while a bank is being filled
      if (apbWrite && paddr == icbs_pkg::OFS_CFG0 && state_q == IDLE) begin
         enable_d = pwdata[15:0];
         modeSel_d = pwdata[icbs_pkg::MODE_BIT];
      end else if (apbWrite && paddr == icbs_pkg::OFS_CFG1) begin
         noDisable_d = pwdata[15:0];
      end else if (apbWrite && paddr == icbs_pkg::OFS_COUNT && state_q == IDLE) begin
         bankCount_d = pwdata[5:0];
      end else if (apbWrite && paddr == icbs_pkg::OFS_LIMIT) begin
         limit_d = pwdata[5:0];
      end else if (apbWrite && paddr == icbs_pkg::OFS_INITPTR && state_q == IDLE) begin
         initPtr_d = pwdata;
      end
      case (state_q)
         IDLE: begin
            if (irqAccept && candidate && !depthOk) begin
               system_error_exc_d = 1'b1;
            end else if (irqAccept && candidate) begin
               state_d = STORE;
               wordIdx_d = 6'h00;
               prioIdx_d = acceptIdx;
               start_d = bankStart(initPtr_q, bankCount_q, modeSel_q);
               memReq_d = 1'b1;
               memAddr_d = bankStart(initPtr_q, bankCount_q, modeSel_q) - icbs_pkg::WORD_BYTES;
               memWdata_d = selData;
            end else if (irqAccept) begin
               handlerStart_d = 1'b1;
               irqDis_d = 1'b1;
            end
         end
         STORE: begin
            if (memDone && memProtViol) begin
               // fault aborts the bank; count untouched so a retry reuses it
               memReq_d = 1'b0;
               memProtExc_d = 1'b1;
               state_d = IDLE;
            end else if (memDone && lastWord) begin
               memReq_d = 1'b0;
               bankCount_d = bankCount_q + 6'h01;
               handlerStart_d = 1'b1;
               bankUsed_d = 1'b1;
               irqDis_d = noDisable_q[prioIdx_q];
               state_d = IDLE;
            end else if (memDone) begin
               wordIdx_d = wordIdx_q + 6'h01;
               memAddr_d = memAddr_q - icbs_pkg::WORD_BYTES;
               memWdata_d = selData;
            end
         end
         default: state_d = IDLE;
      endcase
   end

   // register stage
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         enable_q <= icbs_pkg::RST_ENABLE;
         modeSel_q <= 1'b0;
         noDisable_q <= icbs_pkg::RST_NODIS;
         bankCount_q <= icbs_pkg::RST_COUNT;
         limit_q <= icbs_pkg::RST_LIMIT;
         initPtr_q <= icbs_pkg::RST_INITPTR;
         state_q <= IDLE;
         wordIdx_q <= 6'h00;
         prioIdx_q <= 4'h0;
         start_q <= 32'h0000_0000;
         memReq_q <= 1'b0;
         memAddr_q <= 32'h0000_0000;
         memWdata_q <= 32'h0000_0000;
         handlerStart_q <= 1'b0;
         bankUsed_q <= 1'b0;
         irqDis_q <= 1'b0;
         system_error_exc_q <= 1'b0;
         memProtExc_q <= 1'b0;
      end else if (clockEn) begin
         enable_q <= enable_d;
         modeSel_q <= modeSel_d;
         noDisable_q <= noDisable_d;
         bankCount_q <= bankCount_d;
         limit_q <= limit_d;
         initPtr_q <= initPtr_d;
         state_q <= state_d;
         wordIdx_q <= wordIdx_d;
         prioIdx_q <= prioIdx_d;
         start_q <= start_d;
         memReq_q <= memReq_d;
         memAddr_q <= memAddr_d;
         memWdata_q <= memWdata_d;
         handlerStart_q <= handlerStart_d;
         bankUsed_q <= bankUsed_d;
         irqDis_q <= irqDis_d;
         system_error_exc_q <= system_error_exc_d;
         memProtExc_q <= memProtExc_d;
      end
   end

   // outputs
   assign memReq = memReq_q;
   assign memAddr = memAddr_q;
   assign memWdata = memWdata_q;
   assign holdOff = (state_q == STORE);
   assign handlerStart = handlerStart_q;
   assign bankUsed = bankUsed_q;
   assign guestIrqDisable = irqDis_q;
   assign system_error_exc = system_error_exc_q;
   assign sysErrCode = icbs_pkg::DEPTH_ERR_CODE;
   assign memProtExc = memProtExc_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_no_table_save: assert property (@(posedge clock) disable iff (!resetn)
      (clockEn && state_q == IDLE && irqAccept && !irqTableRef) |=> state_q == IDLE)
      else $error("save started without table vectoring");
   a_enable_gate: assert property (@(posedge clock) disable iff (!resetn)
      (clockEn && state_q == IDLE && irqAccept && !enable_q[acceptIdx]) |=> !holdOff)
      else $error("save started with bank disabled");
   a_low_prio_bit: assert property (@(posedge clock) disable iff (!resetn)
      (clockEn && state_q == IDLE && irqAccept && irqGuest && irqTableRef && irqPrio >= 6'h10
       && enable_q[15] && depthOk) |=> holdOff)
      else $error("low priority did not use bit 15");
   a_host_never: assert property (@(posedge clock) disable iff (!resetn)
      (clockEn && state_q == IDLE && irqAccept && !irqGuest) |=> !holdOff && !system_error_exc)
      else $error("host interrupt touched bank");
   a_depth_error: assert property (@(posedge clock) disable iff (!resetn)
      (clockEn && state_q == IDLE && irqAccept && candidate && bankCount_q == 6'h3f)
      |=> system_error_exc && sysErrCode == 16'h001c && !holdOff)
      else $error("depth overflow not reported");
   a_first_addr: assert property (@(posedge clock) disable iff (!resetn)
      (holdOff && wordIdx_q == 6'h00) |-> memAddr == start_q - 32'h0000_0004)
      else $error("first slot address wrong");
   a_last_addr: assert property (@(posedge clock) disable iff (!resetn)
      (holdOff && modeSel_q && lastWord) |-> memAddr == start_q - 32'h0000_008c)
      else $error("mode 1 last slot address wrong");
   a_count_step: assert property (@(posedge clock) disable iff (!resetn)
      (clockEn && holdOff && memDone && !memProtViol && lastWord)
      |=> bankCount_q == $past(bankCount_q) + 6'h01 && handlerStart && bankUsed)
      else $error("count not stepped after save");
   a_keep_clear: assert property (@(posedge clock) disable iff (!resetn)
      (handlerStart && bankUsed && !noDisable_q[prioIdx_q]) |-> !guestIrqDisable)
      else $error("disable flag set despite no-disable");
   a_write_hold: assert property (@(posedge clock) disable iff (!resetn)
      (memReq && !memDone) |=> memReq && $stable(memAddr) && $stable(memWdata))
      else $error("store dropped before completion");
endmodule : icbs_bank_save
`default_nettype wire

// [hdl/icbs_word_sel.sv]
`timescale 1ns/1ps
`default_nettype none
// maps a save-order index onto the register stored in that slot
module icbs_word_sel (
   input wire logic [5:0] wordIdx, // save order, 0 based
   input wire logic modeSel, // save mode
   output icbs_pkg::icbs_src_type src, // source kind
   output logic [4:0] gprIdx, // general register number
   output logic lastWord // final slot of the bank
);
   // four special words first, then r1 upward; mode 0 ends on r30
   always_comb begin
      gprIdx = 5'h00;
      src = icbs_pkg::SRC_GPR;
      if (wordIdx == 6'h00) begin
         src = icbs_pkg::SRC_PC;
      end else if (wordIdx == 6'h01) begin
         src = icbs_pkg::SRC_STATUS;
      end else if (wordIdx == 6'h02) begin
         src = icbs_pkg::SRC_CAUSE;
      end else if (wordIdx == 6'h03) begin
         src = icbs_pkg::SRC_FPU;
      end else if (!modeSel && wordIdx == icbs_pkg::WORDS_MODE0 - 6'h01) begin
         gprIdx = 5'h1e; // r30 closes the short bank
      end else begin
         gprIdx = 5'(wordIdx - 6'h03);
      end
      lastWord = modeSel ? (wordIdx == icbs_pkg::WORDS_MODE1 - 6'h01)
                         : (wordIdx == icbs_pkg::WORDS_MODE0 - 6'h01);
   end
endmodule : icbs_word_sel
`default_nettype wire

// [inc/icbs_pkg.sv]
package icbs_pkg;
   // bank geometry
   localparam logic [31:0] BANK_SIZE_MODE0 = 32'h0000_0060;
   localparam logic [31:0] BANK_SIZE_MODE1 = 32'h0000_0090;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam logic [5:0] WORDS_MODE0 = 6'h18;
   localparam logic [5:0] WORDS_MODE1 = 6'h23;
   localparam logic [5:0] COUNT_MAX = 6'h3f;
   localparam logic [3:0] LOW_PRIO_BIT = 4'hf;
   localparam logic [15:0] DEPTH_ERR_CODE = 16'h001c;
   // register offsets
   localparam logic [11:0] OFS_CFG0 = 12'h000;
   localparam logic [11:0] OFS_CFG1 = 12'h004;
   localparam logic [11:0] OFS_COUNT = 12'h008;
   localparam logic [11:0] OFS_LIMIT = 12'h00c;
   localparam logic [11:0] OFS_INITPTR = 12'h010;
   localparam logic [11:0] OFS_STATUS = 12'h014;
   // field positions
   localparam int MODE_BIT = 16;
   // reset values
   localparam logic [15:0] RST_ENABLE = 16'h0000;
   localparam logic [15:0] RST_NODIS = 16'hffff;
   localparam logic [5:0] RST_COUNT = 6'h00;
   localparam logic [5:0] RST_LIMIT = 6'h00;
   localparam logic [31:0] RST_INITPTR = 32'h0000_0000;
   // word sources
   typedef enum logic [2:0] {SRC_PC, SRC_STATUS, SRC_CAUSE, SRC_FPU, SRC_GPR} icbs_src_type;
endpackage : icbs_pkg

// [tb/icbs_bank_save_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module icbs_bank_save_tb_top;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic clockEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irqAccept = 1'b0, irqGuest = 1'b0, irqTableRef = 1'b0;
   logic [5:0] irqPrio = 6'h00;
   logic [31:0] ctxPc = 32'h1000_0aa0, ctxStatus = 32'h0000_0020;
   logic [31:0] ctxCause = 32'h0000_1005, ctxFpu = 32'h0002_0000;
   logic [4:0] gprIdx;
   logic [31:0] gprData, memAddr, memWdata, rd;
   logic memReq, memDone, memProtViol, holdOff, handlerStart, bankUsed, guestIrqDisable;
   logic system_error_exc, memProtExc, err, evHs, evSe, evPe, evGid, evBu, evHo;
   logic [15:0] sysErrCode;
   logic [1:0] lat = 2'h0;
   logic [5:0] faultAt = 6'h3f;
   logic [31:0] logA [0:63];
   logic [31:0] logD [0:63];
   int nLog = 0;
   int n_errors = 0;
   int check_count = 0;

   always #5 clock = ~clock;

   icbs_bank_save icbs_bank_save_i (.clock(clock), .resetn(resetn), .clockEn(clockEn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqAccept(irqAccept),
      .irqGuest(irqGuest), .irqTableRef(irqTableRef), .irqPrio(irqPrio), .ctxPc(ctxPc),
      .ctxStatus(ctxStatus), .ctxCause(ctxCause), .ctxFpu(ctxFpu), .gprIdx(gprIdx),
      .gprData(gprData), .memReq(memReq), .memAddr(memAddr), .memWdata(memWdata),
      .memDone(memDone), .memProtViol(memProtViol), .holdOff(holdOff),
      .handlerStart(handlerStart), .bankUsed(bankUsed), .guestIrqDisable(guestIrqDisable),
      .system_error_exc(system_error_exc), .sysErrCode(sysErrCode), .memProtExc(memProtExc));

   icbs_mem_model icbs_mem_model_i (.clock(clock), .resetn(resetn), .memReq(memReq),
      .gprIdx(gprIdx), .lat(lat), .faultAt(faultAt), .memDone(memDone),
      .memProtViol(memProtViol), .gprData(gprData));

   ////////////////////////////////////////////////////////////////////////////////
   // log every word the memory side completes, faulted ones included
   always @(posedge clock) begin
      if (memReq === 1'b1 && memDone === 1'b1 && nLog < 64) begin
         logA[nLog] = memAddr;
         logD[nLog] = memWdata;
         nLog++;
      end
   end

   task chkv(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkv

   task conclude;
      $display("checks=%0d mismatches=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   // one apb transfer; pready is waited for, never assumed
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (pready !== 1'b1 && i < 100);
      if (i >= 100) begin
         n_errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chkv(rd, exp);
   endtask : rdchk

   // pulse an acceptance and wait for whichever outcome comes first
   task irq(input logic g, input logic t, input logic [5:0] p);
      int i;
      nLog = 0;
      @(posedge clock);
      irqAccept <= 1'b1;
      irqGuest <= g;
      irqTableRef <= t;
      irqPrio <= p;
      @(posedge clock);
      irqAccept <= 1'b0;
      i = 0;
      do begin
         @(negedge clock);
         i++;
         if (memReq === 1'b1) chkv({31'h0, holdOff}, 32'h1);
         {evHs, evSe, evPe} = {handlerStart, system_error_exc, memProtExc};
         {evGid, evBu, evHo} = {guestIrqDisable, bankUsed, holdOff};
      end while (evHs !== 1'b1 && evSe !== 1'b1 && evPe !== 1'b1 && i < 400);
      if (i >= 400) begin
         n_errors++;
         conclude();
      end
   endtask : irq

   // outcome kind {fault, depth error, handler}, flag values and word count
   task chkEv(input logic [2:0] ev, input logic gid, input logic bu, input int nw);
      chkv({29'h0, evPe, evSe, evHs}, {29'h0, ev});
      chkv(32'(nLog), 32'(nw));
      if (ev == 3'b001) begin
         chkv({30'h0, evGid, evBu}, {30'h0, gid, bu});
         chkv({31'h0, evHo}, 32'h0);
      end
   endtask : chkEv

   // word k lands at start - 4 - 4k, start = base - count * size
   task chkBank(input logic md, input logic [5:0] cnt, input logic [31:0] base);
      int k;
      logic [31:0] start;
      logic [31:0] w;
      start = base - {26'h0, cnt} * (md ? 32'h90 : 32'h60);
      for (k = 0; k < (md ? 35 : 24); k++) begin
         if (k < 4) w = (k == 0) ? ctxPc : (k == 1) ? ctxStatus : (k == 2) ? ctxCause : ctxFpu;
         else if (!md && k == 23) w = 32'hc0de_001e;
         else w = {16'hc0de, 11'h000, 5'(k - 3)};
         chkv(logA[k], start - 32'h4 - 32'h4 * 32'(k));
         chkv(logD[k], w);
      end
   endtask : chkBank

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      chkv({16'h0, sysErrCode}, 32'h1c);
      rdchk(icbs_pkg::OFS_CFG0, 32'h0);
      rdchk(icbs_pkg::OFS_CFG1, 32'hffff);
      rdchk(icbs_pkg::OFS_COUNT, 32'h0);
      rdchk(icbs_pkg::OFS_LIMIT, 32'h0);
      rdchk(icbs_pkg::OFS_INITPTR, 32'h0);
      rdchk(icbs_pkg::OFS_STATUS, 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      chkv({31'h0, err}, 32'h1);
      // a write while the clock enable is low must leave the register frozen
      @(posedge clock) clockEn <= 1'b0;
      apb(1'b1, icbs_pkg::OFS_LIMIT, 32'h7);
      @(posedge clock) clockEn <= 1'b1;
      rdchk(icbs_pkg::OFS_LIMIT, 32'h0);
      $display("test registers done");
      // enable bit off, then host mode, then direct vectoring: no save
      irq(1'b1, 1'b1, 6'h03);
      chkEv(3'b001, 1'b1, 1'b0, 0);
      apb(1'b1, icbs_pkg::OFS_CFG0, 32'h0000_8008);
      irq(1'b0, 1'b1, 6'h03);
      chkEv(3'b001, 1'b1, 1'b0, 0);
      irq(1'b1, 1'b0, 6'h03);
      chkEv(3'b001, 1'b1, 1'b0, 0);
      $display("test no_save done");
      // mode 0, fast then slow memory, low priority through bit 15
      apb(1'b1, icbs_pkg::OFS_CFG1, 32'h0000_8000);
      apb(1'b1, icbs_pkg::OFS_LIMIT, 32'h5);
      apb(1'b1, icbs_pkg::OFS_INITPTR, 32'h0000_2000);
      irq(1'b1, 1'b1, 6'h03);
      chkEv(3'b001, 1'b0, 1'b1, 24);
      chkBank(1'b0, 6'h00, 32'h0000_2000);
      rdchk(icbs_pkg::OFS_COUNT, 32'h1);
      @(posedge clock) lat <= 2'h3;
      irq(1'b1, 1'b1, 6'h14);
      chkEv(3'b001, 1'b1, 1'b1, 24);
      chkBank(1'b0, 6'h01, 32'h0000_2000);
      rdchk(icbs_pkg::OFS_COUNT, 32'h2);
      $display("test mode0 done");
      // mode 1 with count equal to the limit
      @(posedge clock) lat <= 2'h0;
      apb(1'b1, icbs_pkg::OFS_CFG0, 32'h0001_8000);
      apb(1'b1, icbs_pkg::OFS_LIMIT, 32'h2);
      apb(1'b1, icbs_pkg::OFS_INITPTR, 32'h0000_4000);
      irq(1'b1, 1'b1, 6'h10);
      chkEv(3'b001, 1'b1, 1'b1, 35);
      chkBank(1'b1, 6'h02, 32'h0000_4000);
      rdchk(icbs_pkg::OFS_COUNT, 32'h3);
      $display("test mode1 done");
      // count above limit, then count at 63
      irq(1'b1, 1'b1, 6'h10);
      chkEv(3'b010, 1'b0, 1'b0, 0);
      rdchk(icbs_pkg::OFS_COUNT, 32'h3);
      apb(1'b1, icbs_pkg::OFS_LIMIT, 32'h3f);
      apb(1'b1, icbs_pkg::OFS_COUNT, 32'h3f);
      irq(1'b1, 1'b1, 6'h10);
      chkEv(3'b010, 1'b0, 1'b0, 0);
      $display("test depth done");
      // protection fault on the sixth store aborts the save
      apb(1'b1, icbs_pkg::OFS_COUNT, 32'h0);
      @(posedge clock) faultAt <= 6'h05;
      irq(1'b1, 1'b1, 6'h10);
      chkEv(3'b100, 1'b0, 1'b0, 6);
      rdchk(icbs_pkg::OFS_COUNT, 32'h0);
      $display("test fault done");
      conclude();
   end
endmodule : icbs_bank_save_tb_top
`default_nettype wire

// [tb/icbs_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// far side of the save unit: register file read port and word write path
module icbs_mem_model (
   input wire logic clock, // cpu clock
   input wire logic resetn, // async, active low
   input wire logic memReq, // word write request
   input wire logic [4:0] gprIdx, // register file index
   input wire logic [1:0] lat, // idle cycles before each completion
   input wire logic [5:0] faultAt, // word number that faults, 0x3f none
   output logic memDone, // write finished, pulse
   output logic memProtViol, // fault, only with memDone
   output logic [31:0] gprData // register file data
);
   logic [1:0] waitQ;
   logic [1:0] waitD;
   logic [5:0] wordQ;
   logic [5:0] wordD;
   logic doneQ;
   logic doneD;

   ////////////////////////////////////////////////////////////////////////////////
   // register contents carry their own index so slot order is visible
   assign gprData = {16'hc0de, 11'h000, gprIdx};
   // a completed write counts as committed; software orders later reads itself
   assign memDone = doneQ;
   assign memProtViol = doneQ && (wordQ == faultAt);

   ////////////////////////////////////////////////////////////////////////////////
   // one completion per word, never two in a row, so each word is seen alone
   always_comb begin
      waitD = waitQ;
      wordD = wordQ;
      doneD = 1'b0;
      if (!memReq) begin
         waitD = 2'h0;
         wordD = 6'h00;
      end else if (doneQ) begin
         waitD = 2'h0;
         wordD = wordQ + 6'h01;
      end else if (waitQ == lat) begin
         doneD = 1'b1;
      end else begin
         waitD = waitQ + 2'h1;
      end
   end

   // state registers
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         waitQ <= 2'h0;
         wordQ <= 6'h00;
         doneQ <= 1'b0;
      end else begin
         waitQ <= waitD;
         wordQ <= wordD;
         doneQ <= doneD;
      end
   end
endmodule : icbs_mem_model
`default_nettype wire
